// ---- inc/aqdc_regs.vh ----
// Register map, field positions, codes and reset values of the queued converter control
`ifndef AQDC_REGS_VH
`define AQDC_REGS_VH
// Byte offsets on the register port
`define AQDC_OFS_CTRL 8'h00
`define AQDC_OFS_TRIG 8'h04
`define AQDC_OFS_GAIN 8'h08
`define AQDC_OFS_BIAS 8'h0C
`define AQDC_OFS_CQ0 8'h10
`define AQDC_OFS_CQ1 8'h14
`define AQDC_OFS_PRIO 8'h18
`define AQDC_OFS_COEF 8'h1C
`define AQDC_OFS_FIN 8'h20
`define AQDC_OFS_FOUT 8'h24
`define AQDC_OFS_STAT 8'h28
`define AQDC_OFS_QCLR 8'h2C
// Control register fields
`define AQDC_CTRL_STREAM 0
`define AQDC_CTRL_FEN 1
`define AQDC_CTRL_FINT 2
`define AQDC_CTRL_FIIR 3
`define AQDC_CTRL_TSEN 4
`define AQDC_CTRL_TSSEL 5
`define AQDC_CTRL_DEC 8
`define AQDC_CTRL_RST 16'h0000
// Trigger select: per queue 2-bit source then 2-bit timer index
`define AQDC_TRIG_QW 4
`define AQDC_TRIG_IDX 2
`define AQDC_TRIG_LEGACY 2'h0
`define AQDC_TRIG_PIT 2'h1
`define AQDC_TRIG_TPAND 2'h2
`define AQDC_TRIG_RST 8'h00
// Gain and bias codes, two bits per differential channel
`define AQDC_GAIN_X1 2'h0
`define AQDC_GAIN_X2 2'h1
`define AQDC_GAIN_X4 2'h2
`define AQDC_BIAS_NONE 2'h0
`define AQDC_BIAS_UP 2'h1
`define AQDC_BIAS_DOWN 2'h2
`define AQDC_BIAS_CENTRE 2'h3
// Queue depths and identifiers
`define AQDC_Q0_DEPTH_LEGACY 4'h4
`define AQDC_Q0_DEPTH_STREAM 4'h8
`define AQDC_Q1_DEPTH 4'h4
`define AQDC_QID_PRIO 2'h2
// Coefficient write: index field position, filter tap layout
`define AQDC_COEF_IDX 24
`define AQDC_FIR_LAST 4'h8
`define AQDC_IIR_FB 4'h5
`define AQDC_FRAC 23
`endif

// ---- src/aqdc_top.v ----
// Command queues, priority abort, triggers, analog settings, stamping and decimation filter
//
// Behaviour
// R01 - Without streaming, a command is removed from its queue once dispatched.
// R02 - Streaming option keeps dispatched commands valid in the queue.
// R03 - Only command queue zero can stream; queue one always removes commands.
// R04 - With streaming on, queue zero holds eight commands.
// R05 - Streaming queue converts its stored commands again and again unattended.
// R06 - Priority command aborts the running conversion and is converted next.
// R07 - The aborted conversion is restarted after the priority conversion ends.
// R08 - Filter runs as IIR up to order four or FIR up to eight.
// R09 - Filter uses 24-bit programmable coefficients and a 51-bit accumulator.
// R10 - Standalone filter takes samples from software and returns results there.
// R11 - Integrated filter takes converter results and feeds the result queue.
// R12 - One time base of the shared bus stamps conversion results.
// R13 - Gain per differential channel selects times one, two or four.
// R14 - Bias per channel selects pull-up, pull-down, centre or none.
// R15 - Triggers come from periodic timers or timer outputs ANDed with them.
// R16 - Trigger selection resets to the legacy mapping.
// R17 - All added features reset disabled or legacy compatible.
// R18 - Streaming read pointer wraps to the first entry after the last.
// R19 - Software loads queue zero before streaming and leaves it untouched.
`timescale 1ns/1ps
`include "aqdc_regs.vh"

module aqdc_top #(
	parameter NDIFF = 4,
	parameter NPIT = 4,
	parameter NTB = 4,
	parameter TB_W = 24
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire [1:0] ext_trig,
	input wire [NPIT-1:0] pit_trig,
	input wire [NPIT-1:0] tp_trig,
	input wire [NTB*TB_W-1:0] tb_bus,
	output reg conv_cmd_valid,
	output reg [31:0] conv_cmd_data,
	output reg conv_abort,
	input wire conv_res_valid,
	input wire [15:0] conv_res_data,
	output reg res_valid,
	output reg [15:0] res_data,
	output reg [1:0] res_queue,
	output reg [TB_W-1:0] res_stamp,
	output wire [2*NDIFF-1:0] gain_sel,
	output wire [2*NDIFF-1:0] bias_sel
);

////////////////////////////////////////////////////////////////////////////////
// Configuration registers
reg [15:0] ctrl_r;
reg [7:0] trig_r;
reg [2*NDIFF-1:0] gain_r;
reg [2*NDIFF-1:0] bias_r;
wire stream = ctrl_r[`AQDC_CTRL_STREAM];
wire f_en = ctrl_r[`AQDC_CTRL_FEN];
wire f_int = ctrl_r[`AQDC_CTRL_FINT];
wire f_iir = ctrl_r[`AQDC_CTRL_FIIR];
wire ts_en = ctrl_r[`AQDC_CTRL_TSEN];
wire [1:0] ts_sel = ctrl_r[`AQDC_CTRL_TSSEL +: 2];
wire [3:0] dec_n = ctrl_r[`AQDC_CTRL_DEC +: 4];
wire wr_hit = reg_wr;

assign gain_sel = gain_r; // see R13
assign bias_sel = bias_r; // see R14

// Reset leaves streaming, filter, stamping off and gain x1, no bias
always @(posedge sys_clk) begin
	if (!rst_n) begin
		ctrl_r <= `AQDC_CTRL_RST; // see R17
		trig_r <= `AQDC_TRIG_RST; // see R16
		gain_r <= {NDIFF{`AQDC_GAIN_X1}};
		bias_r <= {NDIFF{`AQDC_BIAS_NONE}};
	end else if (wr_hit) begin
		case (reg_addr)
			`AQDC_OFS_CTRL: ctrl_r <= reg_wdata[15:0];
			`AQDC_OFS_TRIG: trig_r <= reg_wdata[7:0];
			`AQDC_OFS_GAIN: gain_r <= reg_wdata[2*NDIFF-1:0];
			`AQDC_OFS_BIAS: bias_r <= reg_wdata[2*NDIFF-1:0];
			default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Trigger selection; the legacy pins are asynchronous, timer outputs share the clock
reg [1:0] ext_s1_r;
reg [1:0] ext_s2_r;
reg [1:0] tprev_r;
reg [1:0] tsel;
reg [1:0] src;
reg [1:0] idx;
integer t;

always @(posedge sys_clk) begin
	if (!rst_n) begin
		ext_s1_r <= 2'h0;
		ext_s2_r <= 2'h0;
		tprev_r <= 2'h0;
	end else begin
		ext_s1_r <= ext_trig;
		ext_s2_r <= ext_s1_r;
		tprev_r <= tsel;
	end
end

// Each queue picks its start source
always @* begin
	tsel = 2'h0;
	src = 2'h0;
	idx = 2'h0;
	for (t = 0; t < 2; t = t + 1) begin
		src = trig_r[t*`AQDC_TRIG_QW +: 2];
		idx = trig_r[t*`AQDC_TRIG_QW+`AQDC_TRIG_IDX +: 2];
		case (src)
			`AQDC_TRIG_PIT: tsel[t] = pit_trig[idx]; // see R15
			`AQDC_TRIG_TPAND: tsel[t] = tp_trig[idx] & pit_trig[idx]; // see R15
			default: tsel[t] = ext_s2_r[t];
		endcase
	end
end
wire [1:0] trig_edge = tsel & ~tprev_r;

////////////////////////////////////////////////////////////////////////////////
// Command queues and dispatch to the converter
reg [31:0] cq_mem [0:15];
reg [5:0] rp_r;
reg [5:0] wp_r;
reg [7:0] cnt_r;
reg [1:0] armed_r;
reg busy_r;
reg [1:0] cur_q_r;
reg [31:0] cur_cmd_r;
reg prio_pend_r;
reg [31:0] prio_cmd_r;
reg resume_pend_r;
reg [1:0] resume_q_r;
reg [31:0] resume_cmd_r;
wire [3:0] cnt0 = cnt_r[3:0];
wire [3:0] cnt1 = cnt_r[7:4];
wire [3:0] depth0 = stream ? `AQDC_Q0_DEPTH_STREAM : `AQDC_Q0_DEPTH_LEGACY; // see R04
wire [2:0] rp0 = rp_r[2:0];
wire [2:0] rp1 = rp_r[5:3];
wire [2:0] rp0_inc = rp0 + 3'h1;
wire [2:0] rp1_inc = rp1 + 3'h1;
wire go0 = armed_r[0] && cnt0 != 4'h0;
wire go1 = armed_r[1] && cnt1 != 4'h0;
wire res_done = conv_res_valid && busy_r;
wire do_abort = prio_pend_r && busy_r && cur_q_r != `AQDC_QID_PRIO && !res_done;
wire idle = !busy_r || res_done;
wire push0 = wr_hit && reg_addr == `AQDC_OFS_CQ0 && cnt0 < depth0;
wire push1 = wr_hit && reg_addr == `AQDC_OFS_CQ1 && cnt1 < `AQDC_Q1_DEPTH;
wire prio_wr = wr_hit && reg_addr == `AQDC_OFS_PRIO;
wire [TB_W-1:0] tb_pick = tb_bus[ts_sel*TB_W +: TB_W];
integer q;

always @(posedge sys_clk) begin
	if (!rst_n) begin
		rp_r <= 6'h00;
		wp_r <= 6'h00;
		cnt_r <= 8'h00;
		armed_r <= 2'h0;
		busy_r <= 1'b0;
		cur_q_r <= 2'h0;
		cur_cmd_r <= 32'h0000_0000;
		prio_pend_r <= 1'b0;
		prio_cmd_r <= 32'h0000_0000;
		resume_pend_r <= 1'b0;
		resume_q_r <= 2'h0;
		resume_cmd_r <= 32'h0000_0000;
		conv_cmd_valid <= 1'b0;
		conv_cmd_data <= 32'h0000_0000;
		conv_abort <= 1'b0;
	end else begin
		conv_cmd_valid <= 1'b0;
		conv_abort <= 1'b0;
		// Trigger edges arm a queue; a FIFO queue disarms once drained
		for (q = 0; q < 2; q = q + 1) begin
			if (trig_edge[q])
				armed_r[q] <= 1'b1;
		end
		// Pushes; a full queue ignores the write
		if (push0) begin
			cq_mem[{1'b0, wp_r[2:0]}] <= reg_wdata;
			wp_r[2:0] <= wp_r[2:0] + 3'h1;
		end
		if (push1) begin
			cq_mem[{1'b1, wp_r[5:3]}] <= reg_wdata;
			wp_r[5:3] <= wp_r[5:3] + 3'h1;
		end
		if (prio_wr) begin
			prio_pend_r <= 1'b1;
			prio_cmd_r <= reg_wdata;
		end
		if (res_done)
			busy_r <= 1'b0;
		// Counts: pushes add, FIFO dispatch subtracts below
		cnt_r <= {cnt1 + {3'h0, push1}, cnt0 + {3'h0, push0}};
		if (do_abort) begin
			// Priority bypasses queued work and kills the running conversion
			conv_abort <= 1'b1; // see R06
			busy_r <= 1'b0;
			resume_pend_r <= 1'b1; // see R07
			resume_q_r <= cur_q_r;
			resume_cmd_r <= cur_cmd_r;
		end else if (idle && prio_pend_r) begin
			conv_cmd_valid <= 1'b1; // see R06
			conv_cmd_data <= prio_cmd_r;
			cur_cmd_r <= prio_cmd_r;
			cur_q_r <= `AQDC_QID_PRIO;
			busy_r <= 1'b1;
			prio_pend_r <= prio_wr; // A priority written in this very cycle is not lost
		end else if (idle && resume_pend_r) begin
			conv_cmd_valid <= 1'b1; // see R07
			conv_cmd_data <= resume_cmd_r;
			cur_cmd_r <= resume_cmd_r;
			cur_q_r <= resume_q_r;
			busy_r <= 1'b1;
			resume_pend_r <= 1'b0;
		end else if (idle && go0) begin
			conv_cmd_valid <= 1'b1;
			conv_cmd_data <= cq_mem[{1'b0, rp0}];
			cur_cmd_r <= cq_mem[{1'b0, rp0}];
			cur_q_r <= 2'h0;
			busy_r <= 1'b1;
			if (stream) begin
				// Entries stay valid and are replayed from the first one
				rp_r[2:0] <= ({1'b0, rp0_inc} == cnt0) ? 3'h0 : rp0_inc; // see R02 R05 R18
			end else begin
				rp_r[2:0] <= rp0_inc;
				cnt_r[3:0] <= cnt0 - 4'h1 + {3'h0, push0}; // see R01
				if (cnt0 == 4'h1 && !trig_edge[0])
					armed_r[0] <= 1'b0;
			end
		end else if (idle && go1) begin
			// Queue one never streams
			conv_cmd_valid <= 1'b1;
			conv_cmd_data <= cq_mem[{1'b1, rp1}];
			cur_cmd_r <= cq_mem[{1'b1, rp1}];
			cur_q_r <= 2'h1;
			busy_r <= 1'b1;
			rp_r[5:3] <= rp1_inc;
			cnt_r[7:4] <= cnt1 - 4'h1 + {3'h0, push1}; // see R01 R03
			if (cnt1 == 4'h1 && !trig_edge[1])
				armed_r[1] <= 1'b0;
		end
		// Flush restarts a queue so streaming commands can be reloaded
		if (wr_hit && reg_addr == `AQDC_OFS_QCLR) begin
			for (q = 0; q < 2; q = q + 1) begin
				if (reg_wdata[q]) begin
					rp_r[q*3 +: 3] <= 3'h0;
					wp_r[q*3 +: 3] <= 3'h0;
					cnt_r[q*4 +: 4] <= 4'h0;
					armed_r[q] <= 1'b0;
				end
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Decimation filter: one multiply-accumulate per cycle over nine taps
reg signed [23:0] coef_r [0:8];
reg signed [15:0] xh_r [0:8];
reg signed [15:0] yh_r [0:3];
reg signed [50:0] acc_r;
reg [3:0] k_r;
reg f_busy_r;
reg [3:0] dec_cnt_r;
reg [1:0] f_q_r;
reg [TB_W-1:0] f_stamp_r;
reg [15:0] fout_r;
reg fout_v_r;
reg signed [15:0] op;
wire [3:0] kfb = k_r - `AQDC_IIR_FB;
wire signed [39:0] prod = coef_r[k_r] * op;
wire signed [50:0] acc_sum = acc_r + {{11{prod[39]}}, prod}; // see R09
wire [15:0] y_out = acc_sum[`AQDC_FRAC+15:`AQDC_FRAC];
wire fin_wr = wr_hit && reg_addr == `AQDC_OFS_FIN && f_en && !f_int; // see R10
wire fint_in = res_done && !do_abort && f_en && f_int; // see R11
wire f_start = (fin_wr || fint_in) && !f_busy_r;
wire [15:0] f_sample = f_int ? conv_res_data : reg_wdata[15:0];
wire f_last = k_r == `AQDC_FIR_LAST;
wire fout_rd = reg_rd && reg_addr == `AQDC_OFS_FOUT;
integer i;

// Taps above the feedback point read past outputs in IIR mode
always @* begin
	op = xh_r[k_r];
	if (f_iir && k_r >= `AQDC_IIR_FB)
		op = yh_r[kfb[1:0]]; // see R08
end

// Coefficient writes carry their tap index
always @(posedge sys_clk) begin
	if (wr_hit && reg_addr == `AQDC_OFS_COEF)
		coef_r[reg_wdata[`AQDC_COEF_IDX +: 4]] <= reg_wdata[23:0]; // see R09
end

// Samples that arrive while the filter is busy are dropped; nine cycles is far
// below a conversion time, so this only bites on back-to-back software writes
always @(posedge sys_clk) begin
	if (!rst_n) begin
		acc_r <= 51'h0;
		k_r <= 4'h0;
		f_busy_r <= 1'b0;
		dec_cnt_r <= 4'h0;
		f_q_r <= 2'h0;
		f_stamp_r <= {TB_W{1'b0}};
		fout_r <= 16'h0000;
		fout_v_r <= 1'b0;
		for (i = 0; i < 9; i = i + 1)
			xh_r[i] <= 16'h0000;
		for (i = 0; i < 4; i = i + 1)
			yh_r[i] <= 16'h0000;
	end else begin
		if (fout_rd)
			fout_v_r <= 1'b0;
		if (f_start) begin
			for (i = 8; i > 0; i = i - 1)
				xh_r[i] <= xh_r[i-1];
			xh_r[0] <= f_sample;
			acc_r <= 51'h0;
			k_r <= 4'h0;
			f_busy_r <= 1'b1;
			f_q_r <= cur_q_r;
			f_stamp_r <= ts_en ? tb_pick : {TB_W{1'b0}};
		end else if (f_busy_r) begin
			acc_r <= acc_sum;
			k_r <= k_r + 4'h1;
			if (f_last) begin
				f_busy_r <= 1'b0;
				for (i = 3; i > 0; i = i - 1)
					yh_r[i] <= yh_r[i-1];
				yh_r[0] <= y_out;
				dec_cnt_r <= (dec_cnt_r == dec_n) ? 4'h0 : dec_cnt_r + 4'h1;
				if (dec_cnt_r == dec_n && !f_int) begin
					fout_r <= y_out; // see R10
					fout_v_r <= 1'b1;
				end
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Result port: direct converter results or decimated filter output
always @(posedge sys_clk) begin
	if (!rst_n) begin
		res_valid <= 1'b0;
		res_data <= 16'h0000;
		res_queue <= 2'h0;
		res_stamp <= {TB_W{1'b0}};
	end else begin
		res_valid <= 1'b0;
		if (f_busy_r && f_last && f_int && dec_cnt_r == dec_n) begin
			res_valid <= 1'b1; // see R11
			res_data <= y_out;
			res_queue <= f_q_r;
			res_stamp <= f_stamp_r;
		end else if (res_done && !do_abort && !(f_en && f_int)) begin
			res_valid <= 1'b1;
			res_data <= conv_res_data;
			res_queue <= cur_q_r;
			res_stamp <= ts_en ? tb_pick : {TB_W{1'b0}}; // see R12
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read port: data stand only in the cycle after the strobe
reg [31:0] rd_val;
always @* begin
	case (reg_addr)
		`AQDC_OFS_CTRL: rd_val = {16'h0000, ctrl_r};
		`AQDC_OFS_TRIG: rd_val = {24'h000000, trig_r};
		`AQDC_OFS_GAIN: rd_val = {{(32-2*NDIFF){1'b0}}, gain_r};
		`AQDC_OFS_BIAS: rd_val = {{(32-2*NDIFF){1'b0}}, bias_r};
		`AQDC_OFS_FOUT: rd_val = {16'h0000, fout_r};
		`AQDC_OFS_STAT: rd_val = {17'h0, f_busy_r, armed_r, resume_pend_r,
			prio_pend_r, fout_v_r, busy_r, cnt1, cnt0};
		default: rd_val = 32'h0000_0000;
	endcase
end

always @(posedge sys_clk) begin
	if (!rst_n)
		reg_rdata <= 32'h0000_0000;
	else
		reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
end

endmodule

// ---- test/aqdc_conv_model.sv ----
// Behavioural converter answering each dispatched command that is not aborted after a set latency
`timescale 1ns/1ps
module aqdc_conv_model (
	input wire sys_clk,
	input wire rst_n,
	input wire [7:0] lat,
	input wire conv_cmd_valid,
	input wire [31:0] conv_cmd_data,
	input wire conv_abort,
	output reg conv_res_valid,
	output reg [15:0] conv_res_data
);
	reg [7:0] cnt_r;
	reg [15:0] cmd_r;
	////////////////////////////////////////////////////////////////////////////////
	// One conversion at a time; the data line toggles outside results so stale
	// values are never mistaken for an answer
	always @(posedge sys_clk) begin
		conv_res_valid <= 1'b0;
		conv_res_data <= ~conv_res_data;
		if (!rst_n) begin
			cnt_r <= 8'h00;
			conv_res_data <= 16'h0000;
		end else if (conv_abort) begin
			cnt_r <= 8'h00;
		end else if (conv_cmd_valid) begin
			cnt_r <= lat;
			cmd_r <= conv_cmd_data[15:0];
		end else if (cnt_r == 8'h01) begin
			cnt_r <= 8'h00;
			conv_res_valid <= 1'b1;
			conv_res_data <= cmd_r ^ 16'hA5A5;
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule

// ---- test/aqdc_properties.sv ----
// Port-level checks of the queued converter control
`timescale 1ns/1ps
module aqdc_properties #(
	parameter NDIFF = 4
) (
	input wire sys_clk,
	input wire rst_n,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire conv_cmd_valid,
	input wire conv_abort,
	input wire conv_res_valid,
	input wire res_valid,
	input wire [2*NDIFF-1:0] gain_sel
);
	reg busy_r;
	reg busy_nxt;
	reg gain_ok;
	integer i;
	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the outstanding conversion, so dispatch and abort can be judged
	always @* begin
		busy_nxt = busy_r;
		if (conv_cmd_valid) begin
			busy_nxt = 1'b1;
		end else if (conv_res_valid || conv_abort) begin
			busy_nxt = 1'b0;
		end
	end
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
		end
	end
	// Code three has no gain meaning
	always @* begin
		gain_ok = 1'b1;
		for (i = 0; i < NDIFF; i = i + 1) begin
			if (gain_sel[2*i+:2] == 2'h3) gain_ok = 1'b0;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("Read data present without a read");
	reset_quiet_a: assert property ($rose(rst_n) |-> gain_sel == 0 && !conv_cmd_valid && !res_valid)
		else $error("Outputs active right after reset");
	abort_next_a: assert property (conv_abort |=> conv_cmd_valid)
		else $error("No dispatch right after abort");
	abort_busy_a: assert property (conv_abort |-> busy_r)
		else $error("Abort with no conversion running");
	abort_pulse_a: assert property (conv_abort |=> !conv_abort)
		else $error("Abort longer than one cycle");
	dispatch_idle_a: assert property (conv_cmd_valid |-> !busy_r || conv_res_valid)
		else $error("Dispatch while converter busy");
	gain_legal_a: assert property (gain_ok)
		else $error("Illegal gain code");
	result_cause_a: assert property (res_valid |-> $past(conv_res_valid) || $past(conv_res_valid, 10))
		else $error("Result without converter sample");
endmodule
bind aqdc_top aqdc_properties #(.NDIFF(NDIFF)) aqdc_properties_i (.sys_clk, .rst_n, .reg_rd,
	.reg_rdata, .conv_cmd_valid, .conv_abort, .conv_res_valid, .res_valid, .gain_sel);

// ---- test/tb.sv ----
// Self-checking bench for the queued converter control
`timescale 1ns/1ps
`include "aqdc_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
	reg sys_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [1:0] ext_trig = 2'h0;
	reg [3:0] pit_trig = 4'h0;
	reg [3:0] tp_trig = 4'h0;
	reg [95:0] tb_bus = 96'h0;
	reg [7:0] lat = 8'h05;
	wire [31:0] reg_rdata, conv_cmd_data;
	wire conv_cmd_valid, conv_abort, conv_res_valid, res_valid;
	wire [15:0] conv_res_data, res_data;
	wire [1:0] res_queue;
	wire [23:0] res_stamp;
	wire [7:0] gain_sel, bias_sel;
	integer fail_count = 0;
	integer checks_done = 0;
	integer abort_at = 99;
	integer i, j, k;
	logic [31:0] cmd_q[$];
	logic [41:0] res_q[$];
	logic [31:0] stored[0:7];
	logic [31:0] aborted, d;
	logic [15:0] smp[0:11];
	logic [15:0] xp, yp, r;
	logic [7:0] gv, bv;
	logic [7:0] ofs[0:5] = '{`AQDC_OFS_CTRL, `AQDC_OFS_TRIG, `AQDC_OFS_GAIN, `AQDC_OFS_BIAS,
		`AQDC_OFS_STAT, 8'h30};
	aqdc_top aqdc_top_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ext_trig, .pit_trig, .tp_trig, .tb_bus, .conv_cmd_valid, .conv_cmd_data, .conv_abort,
		.conv_res_valid, .conv_res_data, .res_valid, .res_data, .res_queue, .res_stamp,
		.gain_sel, .bias_sel);
	aqdc_conv_model aqdc_conv_model_i (.sys_clk, .rst_n, .lat, .conv_cmd_valid, .conv_cmd_data,
		.conv_abort, .conv_res_valid, .conv_res_data);
	////////////////////////////////////////////////////////////////////////////////
	always #25 sys_clk = ~sys_clk;
	// Log dispatches, results and the command cut short by an abort
	always @(posedge sys_clk) begin
		if (conv_cmd_valid) cmd_q.push_back(conv_cmd_data);
		if (res_valid) res_q.push_back({res_stamp, res_queue, res_data});
		if (conv_abort) abort_at = cmd_q.size();
		if (conv_abort) aborted = conv_cmd_data;
	end
	task wr(input [7:0] a, input [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a, output [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
	endtask
	task wrap_up;
		if (fail_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Bounded wait for n dispatches and m results; a hang ends the run
	task wait_q(input integer n, input integer m);
		for (k = 0; k < 2000 && (cmd_q.size() < n || res_q.size() < m); k++) @(posedge sys_clk);
		if (cmd_q.size() < n || res_q.size() < m) begin
			fail_count++;
			wrap_up;
		end
	endtask
	function [15:0] exp_res(input [31:0] c);
		exp_res = c[15:0] ^ 16'hA5A5;
	endfunction
	// Two taps: +0.5 on the newest sample, -0.5 on the one before
	function [15:0] fir2(input signed [15:0] a, input signed [15:0] b);
		reg signed [50:0] acc;
		acc = 51'sh400000 * a - 51'sh400000 * b;
		fir2 = acc[38:23];
	endfunction
	// Feedback form: +0.5 newest sample, -0.5 previous sample, +0.5 previous output
	function [15:0] iir1(input signed [15:0] a, input signed [15:0] b, input signed [15:0] c);
		reg signed [50:0] acc;
		acc = 51'sh400000 * a - 51'sh400000 * b + 51'sh400000 * c;
		iir1 = acc[38:23];
	endfunction
	initial begin
		void'($urandom(32'hCC9A));
		tb_bus = {$urandom, $urandom, $urandom};
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		// Reset values, legacy triggers and an unmapped place
		for (i = 0; i < 6; i++) begin
			rd(ofs[i], d);
			`CHK(d, 32'h0)
		end
		`CHK({gain_sel, bias_sel}, 16'h0000)
		// Every gain code on every channel, three of the four bias codes on each
		for (i = 0; i < 3; i++) begin
			for (j = 0; j < 4; j++) gv[2*j+:2] = 2'((i + j) % 3);
			for (j = 0; j < 4; j++) bv[2*j+:2] = 2'((i + j + 1) % 4);
			wr(`AQDC_OFS_GAIN, {24'h0, gv});
			wr(`AQDC_OFS_BIAS, {24'h0, bv});
			repeat (2) @(negedge sys_clk);
			`CHK(gain_sel, gv)
			`CHK(bias_sel, bv)
		end
		// Queue one: a push past full is dropped, timer AND gating, entries removed
		lat <= 8'($urandom_range(6, 2));
		wr(`AQDC_OFS_TRIG, 32'h61);
		for (i = 0; i < 5; i++) begin
			stored[i] = $urandom;
			wr(`AQDC_OFS_CQ1, stored[i]);
		end
		rd(`AQDC_OFS_STAT, d);
		`CHK(d[7:0], 8'h40)
		@(posedge sys_clk) pit_trig[1] <= 1'b1;
		@(posedge sys_clk) pit_trig[1] <= 1'b0;
		repeat (20) @(posedge sys_clk);
		`CHK(cmd_q.size(), 0)
		tp_trig[1] <= 1'b1;
		@(posedge sys_clk) pit_trig[1] <= 1'b1;
		@(posedge sys_clk) pit_trig[1] <= 1'b0;
		wait_q(4, 4);
		repeat (30) @(posedge sys_clk);
		`CHK(cmd_q.size(), 4)
		for (i = 0; i < 4; i++) begin
			`CHK(cmd_q[i], stored[i])
			`CHK(res_q[i], {24'h0, 2'h1, exp_res(stored[i])})
		end
		rd(`AQDC_OFS_STAT, d);
		`CHK(d[7:4], 4'h0)
		// Queue zero streams eight entries with stamping from time base two
		tp_trig[1] <= 1'b0;
		cmd_q.delete();
		res_q.delete();
		wr(`AQDC_OFS_QCLR, 32'h3);
		wr(`AQDC_OFS_CTRL, 32'h51);
		for (i = 0; i < 8; i++) begin
			stored[i] = $urandom;
			wr(`AQDC_OFS_CQ0, stored[i]);
		end
		rd(`AQDC_OFS_STAT, d);
		`CHK(d[3:0], 4'h8)
		@(posedge sys_clk) pit_trig[0] <= 1'b1;
		@(posedge sys_clk) pit_trig[0] <= 1'b0;
		wait_q(12, 10);
		for (i = 0; i < 12; i++) `CHK(cmd_q[i], stored[i % 8])
		for (i = 0; i < 10; i++) `CHK(res_q[i], {tb_bus[71:48], 2'h0, exp_res(stored[i % 8])})
		// Priority command cuts into the stream; the cut command is replayed. Written
		// right after a dispatch, so the abort can never meet a result edge
		@(negedge sys_clk);
		for (k = 0; k < 50 && conv_cmd_valid !== 1'b1; k++) @(negedge sys_clk);
		if (conv_cmd_valid !== 1'b1) begin
			fail_count++;
			wrap_up;
		end
		cmd_q.delete();
		res_q.delete();
		d = $urandom;
		wr(`AQDC_OFS_PRIO, d);
		wait_q(8, 6);
		`CHK(cmd_q[abort_at], d)
		`CHK(cmd_q[abort_at + 1], aborted)
		for (i = 0; i < 6; i++) if (res_q[i][17:16] == 2'h2) smp[0] = res_q[i][15:0];
		`CHK(smp[0], exp_res(d))
		wr(`AQDC_OFS_CTRL, 32'h0);
		wr(`AQDC_OFS_QCLR, 32'h3);
		// Standalone filter, FIR with a signed 24-bit coefficient
		wr(`AQDC_OFS_CTRL, 32'h2);
		for (i = 0; i < 9; i++) begin
			wr(`AQDC_OFS_COEF, {4'h0, 4'(i), i == 0 ? 24'h400000 : i == 1 ? 24'hC00000 : 24'h0});
		end
		for (i = 0; i < 12; i++) begin
			smp[i] = i < 9 ? 16'h0 : 16'($urandom);
			wr(`AQDC_OFS_FIN, {16'h0, smp[i]});
			d = 32'h0;
			for (k = 0; k < 40 && d[9] !== 1'b1; k++) rd(`AQDC_OFS_STAT, d);
			if (d[9] !== 1'b1) begin
				fail_count++;
				wrap_up;
			end
			rd(`AQDC_OFS_FOUT, d);
			if (i > 8) `CHK(d[15:0], fir2(smp[i], smp[i - 1]))
		end
		// Integrated IIR fed by queue one from the legacy pin; every second output kept.
		// A slow converter keeps results apart, since the filter drops samples while busy
		xp = smp[11];
		yp = d[15:0];
		@(posedge sys_clk) lat <= 8'h0C;
		wr(`AQDC_OFS_TRIG, 32'h0);
		wr(`AQDC_OFS_COEF, {8'h05, 24'h400000});
		wr(`AQDC_OFS_CTRL, 32'h10E);
		for (i = 0; i < 4; i++) wr(`AQDC_OFS_CQ1, stored[i]);
		cmd_q.delete();
		res_q.delete();
		@(posedge sys_clk) ext_trig <= 2'h2;
		repeat (4) @(posedge sys_clk);
		ext_trig <= 2'h0;
		wait_q(4, 2);
		repeat (40) @(posedge sys_clk);
		`CHK(res_q.size(), 2)
		for (i = 0; i < 4; i++) begin
			r = exp_res(stored[i]);
			yp = iir1(r, xp, yp);
			xp = r;
			if (i % 2 == 1) `CHK(res_q[i / 2], {24'h0, 2'h1, yp})
		end
		wrap_up;
	end
endmodule
